/* include/timer_link_if.sv */
// signals between the timer top and its tick and gate units
`timescale 1ns/100ps
`default_nettype none
interface timer_link_if;
	logic [1:0] count_clock_select;
	logic [1:0] prescale_select;
	logic sync_disable;
	logic sleep_mode;
	logic count_tick;
	logic async_tick;
	logic [1:0] gate_source_select;
	logic gate_polarity;
	logic gate_toggle_mode;
	logic gate_single_pulse_mode;
	logic gate_go_done;
	logic gate_level;
	logic gate_fall;
	logic go_done_clear;
	modport top_mp (
		output count_clock_select, prescale_select, sync_disable, sleep_mode,
		output gate_source_select, gate_polarity, gate_toggle_mode,
		output gate_single_pulse_mode, gate_go_done,
		input count_tick, async_tick, gate_level, gate_fall, go_done_clear
	);
	modport tick_mp (
		input count_clock_select, prescale_select, sync_disable, sleep_mode,
		output count_tick, async_tick
	);
	modport gate_mp (
		input gate_source_select, gate_polarity, gate_toggle_mode,
		input gate_single_pulse_mode, gate_go_done,
		output gate_level, gate_fall, go_done_clear
	);
endinterface
`default_nettype wire

/* include/timer_pkg.sv */
// constants and types shared by the gated timer design
`default_nettype none
package timer_pkg;
	localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
	localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_GATE = 8'h0C;
	localparam logic [7:0] OFS_INT_STATUS = 8'h10;
	localparam logic [7:0] OFS_INT_MASK = 8'h14;
	// control register fields
	localparam int CTL_TIMER_ON = 0;
	localparam int CTL_SYNC_DISABLE = 1;
	localparam int CTL_PRESCALE_LO = 2;
	localparam int CTL_CLKSEL_LO = 4;
	// gate register fields
	localparam int GATE_ENABLE = 0;
	localparam int GATE_POLARITY = 1;
	localparam int GATE_TOGGLE = 2;
	localparam int GATE_SINGLE_PULSE = 3;
	localparam int GATE_GO_DONE = 4;
	localparam int GATE_LEVEL = 5;
	localparam int GATE_SRC_LO = 6;
	// interrupt bits
	localparam int INT_OVERFLOW = 0;
	localparam int INT_GATE_EVENT = 1;
	// reset values
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [5:0] CONTROL_RESET = 6'h00;
	localparam logic [7:0] GATE_RESET = 8'h00;
	localparam logic [1:0] INT_RESET = 2'h0;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	// internal clock divided by four, as for an instruction clock
	localparam logic [1:0] FOSC4_DIV_LAST = 2'h3;
	typedef enum logic [1:0] {
		CLK_FOSC4 = 2'h0,
		CLK_FOSC = 2'h1,
		CLK_EXT_PIN = 2'h2,
		CLK_LF_OSC = 2'h3
	} clock_select_type;
	typedef enum logic [1:0] {
		GSRC_PIN = 2'h0,
		GSRC_OTHER_OVF = 2'h1,
		GSRC_COMPARATOR = 2'h2,
		GSRC_RESERVED = 2'h3
	} gate_source_type;
	typedef enum logic [2:0] {
		BUS_IDLE = 3'h1,
		BUS_WAIT = 3'h2,
		BUS_DONE = 3'h4
	} bus_state_type;
endpackage
`default_nettype wire

/* rtl/count_tick_gen.sv */
// count clock selection, prescaler and optional synchroniser
`timescale 1ns/100ps
`default_nettype none
module count_tick_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic external_count_pin,
	input wire logic low_freq_internal_osc,
	timer_link_if.tick_mp lnk
);
	logic [1:0] div_ff, nxt_div;
	logic ext_prev_ff, nxt_ext_prev;
	logic lf_prev_ff, nxt_lf_prev;
	logic [2:0] pre_ff, nxt_pre;
	logic sync1_ff, nxt_sync1;
	logic sync2_ff, nxt_sync2;
	logic src_tick;
	logic pre_tick;
	logic [2:0] pre_mask;

	always_comb
	begin
		nxt_div = div_ff + 2'h1;
		nxt_ext_prev = external_count_pin;
		nxt_lf_prev = low_freq_internal_osc;
		// source select
		case (lnk.count_clock_select)
			timer_pkg::CLK_FOSC4: src_tick = (div_ff == timer_pkg::FOSC4_DIV_LAST);
			timer_pkg::CLK_FOSC: src_tick = 1'b1;
			timer_pkg::CLK_EXT_PIN: src_tick = external_count_pin & ~ext_prev_ff;
			timer_pkg::CLK_LF_OSC: src_tick = low_freq_internal_osc & ~lf_prev_ff;
			default: src_tick = 1'b0;
		endcase
		// system clocks stop in sleep
		if (lnk.sleep_mode && lnk.count_clock_select != timer_pkg::CLK_EXT_PIN)
			src_tick = 1'b0;
		// divide by 1, 2, 4 or 8
		pre_mask = 3'((4'h1 << lnk.prescale_select) - 4'h1);
		pre_tick = src_tick && ((pre_ff & pre_mask) == pre_mask);
		nxt_pre = src_tick ? pre_ff + 3'h1 : pre_ff;
		nxt_sync1 = pre_tick & ~lnk.sleep_mode;
		nxt_sync2 = sync1_ff & ~lnk.sleep_mode;
		lnk.async_tick = pre_tick;
		lnk.count_tick = lnk.sync_disable ? pre_tick : sync2_ff;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_ff <= 2'h0;
			ext_prev_ff <= 1'b0;
			lf_prev_ff <= 1'b0;
			pre_ff <= 3'h0;
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end
		else
		begin
			div_ff <= nxt_div;
			ext_prev_ff <= nxt_ext_prev;
			lf_prev_ff <= nxt_lf_prev;
			pre_ff <= nxt_pre;
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end
endmodule // count_tick_gen
`default_nettype wire

/* rtl/gate_unit.sv */
// gate source, polarity, toggle and single-pulse control
`timescale 1ns/100ps
`default_nettype none
module gate_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic gate_pin,
	input wire logic other_timer_overflow,
	input wire logic comparator_out_synced,
	timer_link_if.gate_mp lnk
);
	logic src;
	logic active;
	logic prev_ff, nxt_prev;
	logic tog_ff, nxt_tog;
	logic acq_ff, nxt_acq;
	logic level_ff, nxt_level;
	logic shaped;
	logic shaped_prev_ff, nxt_shaped_prev;

	always_comb
	begin
		case (lnk.gate_source_select)
			timer_pkg::GSRC_PIN: src = gate_pin;
			timer_pkg::GSRC_OTHER_OVF: src = other_timer_overflow;
			timer_pkg::GSRC_COMPARATOR: src = comparator_out_synced;
			default: src = 1'b0;
		endcase
		// polarity: one means active high
		active = src ~^ lnk.gate_polarity;
		nxt_prev = active;
		// toggle on each active edge
		nxt_tog = (active & ~prev_ff) ? ~tog_ff : tog_ff;
		shaped = lnk.gate_toggle_mode ? tog_ff : prev_ff;
		nxt_shaped_prev = shaped;
		// single pulse acquisition
		nxt_acq = acq_ff;
		if (!lnk.gate_single_pulse_mode)
			nxt_acq = 1'b0;
		else if (acq_ff && !shaped)
			nxt_acq = 1'b0;
		else if (lnk.gate_go_done && shaped && !shaped_prev_ff)
			nxt_acq = 1'b1;
		nxt_level = lnk.gate_single_pulse_mode ? acq_ff : shaped;
		lnk.gate_level = level_ff;
		lnk.gate_fall = level_ff & ~nxt_level;
		lnk.go_done_clear = acq_ff & ~nxt_acq;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_ff <= 1'b0;
			tog_ff <= 1'b0;
			acq_ff <= 1'b0;
			level_ff <= 1'b0;
			shaped_prev_ff <= 1'b0;
		end
		else
		begin
			prev_ff <= nxt_prev;
			tog_ff <= nxt_tog;
			acq_ff <= nxt_acq;
			level_ff <= nxt_level;
			shaped_prev_ff <= nxt_shaped_prev;
		end
	end
endmodule // gate_unit
`default_nettype wire

/* rtl/gated_timer.sv */
// gated sixteen-bit timer with apb registers and interrupt
//
// Overview of operation
// - The sixteen-bit count is a high and low byte, both read and written.
// - Software picks the count clock: an internal source or the count pin.
// - A two-bit prescaler divides the selected clock by 1, 2, 4 or 8.
// - The count goes up on each prescaled, optionally synchronised tick.
// - Rollover flags overflow; counting needs timer on and any enabled gate.
// - Overflow in sleep wakes the processor only for the unsynced count pin.
// - The synchroniser halts in sleep; only unsynchronised counting from the count pin runs.
// - Gate source field: pin, other overflow, comparator; code 11 reserved.
// - Polarity picks whether a high or low gate source lets the count run.
// - Single pulse: go/done arms the next active edge, cleared at gate end.
// - The gate event flag sets when an enabled gate's level falls; software clears it.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module gated_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_count_pin,
	input wire logic low_freq_internal_osc,
	input wire logic gate_pin,
	input wire logic other_timer_overflow,
	input wire logic comparator_out_synced,
	input wire logic sleep_mode,
	output logic irq,
	output logic wake,
	output logic overflow_pulse
);
	timer_link_if lnk ();

	timer_pkg::bus_state_type bus_ff, nxt_bus;
	logic [31:0] rdata_ff, nxt_rdata;
	logic ready_ff, nxt_ready;
	logic err_ff, nxt_err;
	logic [15:0] count_ff, nxt_count;
	logic [5:0] control_ff, nxt_control;
	logic [7:0] gate_ff, nxt_gate;
	logic [1:0] status_ff, nxt_status;
	logic [1:0] mask_ff, nxt_mask;
	logic irq_ff, nxt_irq;
	logic wake_ff, nxt_wake;
	logic ovf_ff, nxt_ovf;

	logic access;
	logic wr_commit;
	logic mapped;
	logic timer_on;
	logic gate_enable;
	logic count_en;
	logic tick;
	logic inc;
	logic rollover;
	logic [1:0] events;
	logic [31:0] read_mux;

	count_tick_gen u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.external_count_pin(external_count_pin),
		.low_freq_internal_osc(low_freq_internal_osc),
		.lnk(lnk.tick_mp)
	);

	gate_unit u_gate (
		.pclk(pclk),
		.presetn(presetn),
		.gate_pin(gate_pin),
		.other_timer_overflow(other_timer_overflow),
		.comparator_out_synced(comparator_out_synced),
		.lnk(lnk.gate_mp)
	);

	// configuration to the sub-units
	always_comb
	begin
		lnk.count_clock_select = control_ff[timer_pkg::CTL_CLKSEL_LO +: 2];
		lnk.prescale_select = control_ff[timer_pkg::CTL_PRESCALE_LO +: 2];
		// synchroniser bypass select
		lnk.sync_disable = control_ff[timer_pkg::CTL_SYNC_DISABLE];
		lnk.sleep_mode = sleep_mode;
		lnk.gate_source_select = gate_ff[timer_pkg::GATE_SRC_LO +: 2];
		lnk.gate_polarity = gate_ff[timer_pkg::GATE_POLARITY];
		lnk.gate_toggle_mode = gate_ff[timer_pkg::GATE_TOGGLE];
		lnk.gate_single_pulse_mode = gate_ff[timer_pkg::GATE_SINGLE_PULSE];
		lnk.gate_go_done = gate_ff[timer_pkg::GATE_GO_DONE];
	end

	// apb slave: two wait states, then answer
	always_comb
	begin
		access = psel & penable;
		wr_commit = (bus_ff == timer_pkg::BUS_DONE) & access & pwrite;
		case (paddr)
			timer_pkg::OFS_COUNT_LOW,
			timer_pkg::OFS_COUNT_HIGH,
			timer_pkg::OFS_CONTROL,
			timer_pkg::OFS_GATE,
			timer_pkg::OFS_INT_STATUS,
			timer_pkg::OFS_INT_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
		read_mux = 32'h0000_0000;
		case (paddr)
			timer_pkg::OFS_COUNT_LOW: read_mux[7:0] = count_ff[7:0];
			timer_pkg::OFS_COUNT_HIGH: read_mux[7:0] = count_ff[15:8];
			timer_pkg::OFS_CONTROL: read_mux[5:0] = control_ff;
			timer_pkg::OFS_GATE:
			begin
				read_mux[7:0] = gate_ff;
				read_mux[timer_pkg::GATE_LEVEL] = lnk.gate_level;
			end
			timer_pkg::OFS_INT_STATUS: read_mux[1:0] = status_ff;
			timer_pkg::OFS_INT_MASK: read_mux[1:0] = mask_ff;
			default: read_mux = 32'h0000_0000;
		endcase
		nxt_bus = bus_ff;
		nxt_ready = 1'b0;
		nxt_err = 1'b0;
		nxt_rdata = rdata_ff;
		case (bus_ff)
			timer_pkg::BUS_IDLE:
			begin
				if (access)
				begin
					nxt_bus = timer_pkg::BUS_WAIT;
				end
			end
			timer_pkg::BUS_WAIT:
			begin
				nxt_bus = timer_pkg::BUS_DONE;
				nxt_ready = 1'b1;
				nxt_err = ~mapped;
				nxt_rdata = pwrite ? 32'h0000_0000 : read_mux;
			end
			timer_pkg::BUS_DONE:
			begin
				nxt_bus = timer_pkg::BUS_IDLE;
			end
			default: nxt_bus = timer_pkg::BUS_IDLE;
		endcase
	end

	// count register
	always_comb
	begin
		timer_on = control_ff[timer_pkg::CTL_TIMER_ON];
		gate_enable = gate_ff[timer_pkg::GATE_ENABLE];
		count_en = timer_on & (~gate_enable | lnk.gate_level);
		tick = lnk.count_tick;
		inc = count_en & tick;
		rollover = inc & (count_ff == timer_pkg::COUNT_MAX);
		nxt_count = inc ? count_ff + 16'h0001 : count_ff;
		if (wr_commit && pstrb[0] && paddr == timer_pkg::OFS_COUNT_LOW)
			nxt_count[7:0] = pwdata[7:0];
		if (wr_commit && pstrb[0] && paddr == timer_pkg::OFS_COUNT_HIGH)
			nxt_count[15:8] = pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_ff <= timer_pkg::COUNT_RESET;
		end
		else
		begin
			count_ff <= nxt_count;
		end
	end

	// control, gate and mask registers
	always_comb
	begin
		nxt_control = control_ff;
		if (wr_commit && pstrb[0] && paddr == timer_pkg::OFS_CONTROL)
			nxt_control = pwdata[5:0];
		nxt_gate = gate_ff;
		if (lnk.go_done_clear)
			nxt_gate[timer_pkg::GATE_GO_DONE] = 1'b0;
		if (wr_commit && pstrb[0] && paddr == timer_pkg::OFS_GATE)
			nxt_gate = pwdata[7:0];
		nxt_gate[timer_pkg::GATE_LEVEL] = 1'b0;
		nxt_mask = mask_ff;
		if (wr_commit && pstrb[0] && paddr == timer_pkg::OFS_INT_MASK)
			nxt_mask = pwdata[1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control_ff <= timer_pkg::CONTROL_RESET;
			gate_ff <= timer_pkg::GATE_RESET;
			mask_ff <= timer_pkg::INT_RESET;
		end
		else
		begin
			control_ff <= nxt_control;
			gate_ff <= nxt_gate;
			mask_ff <= nxt_mask;
		end
	end

	// sticky status flags
	always_comb
	begin
		events = 2'h0;
		events[timer_pkg::INT_OVERFLOW] = rollover;
		events[timer_pkg::INT_GATE_EVENT] = gate_enable & lnk.gate_fall;
		nxt_status = status_ff;
		if (wr_commit && pstrb[0] && paddr == timer_pkg::OFS_INT_STATUS)
			nxt_status = status_ff & ~pwdata[1:0];
		nxt_status = nxt_status | events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_ff <= timer_pkg::INT_RESET;
		end
		else
		begin
			status_ff <= nxt_status;
		end
	end

	// registered outputs
	always_comb
	begin
		// interrupt level from masked status
		nxt_irq = |(nxt_status & nxt_mask);
		nxt_wake = rollover & sleep_mode & lnk.sync_disable &
			lnk.async_tick &
			(lnk.count_clock_select == timer_pkg::CLK_EXT_PIN);
		nxt_ovf = rollover;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_ff <= 1'b0;
			wake_ff <= 1'b0;
			ovf_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= nxt_irq;
			wake_ff <= nxt_wake;
			ovf_ff <= nxt_ovf;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_ff <= timer_pkg::BUS_IDLE;
			rdata_ff <= 32'h0000_0000;
			ready_ff <= 1'b0;
			err_ff <= 1'b0;
		end
		else
		begin
			bus_ff <= nxt_bus;
			rdata_ff <= nxt_rdata;
			ready_ff <= nxt_ready;
			err_ff <= nxt_err;
		end
	end

	assign prdata = rdata_ff;
	assign pready = ready_ff;
	assign pslverr = err_ff;
	assign irq = irq_ff;
	assign wake = wake_ff;
	assign overflow_pulse = ovf_ff;
endmodule // gated_timer
`default_nettype wire

/* verification/gated_timer_chk.sv */
// port assertions for the gated timer
`timescale 1ns/100ps
`default_nettype none
module gated_timer_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleep_mode,
	input wire logic wake,
	input wire logic overflow_pulse
);
	logic mapped;
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	assign mapped = paddr[1:0] == 2'h0 && paddr <= timer_pkg::OFS_INT_MASK;
	sequence s_access; $rose(psel && penable); endsequence
	sequence s_answer; (!pready) [*2] ##1 pready; endsequence
	property p_wait; s_access |-> s_answer; endproperty
	a_wait: assert property (p_wait) else $error("answer late");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("answer long");
	property p_err; pslverr |-> pready && psel && penable; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_unmap;
		pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped taken");
	property p_map; pready && mapped |-> !pslverr; endproperty
	a_map: assert property (p_map) else $error("mapped refused");
	property p_byte; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_byte: assert property (p_byte) else $error("upper bits set");
	property p_hold;
		$changed(prdata) |-> pready && (!pwrite || prdata == 32'h0);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_ovf; overflow_pulse |=> !overflow_pulse; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow long");
	property p_wake; wake |-> sleep_mode || $past(sleep_mode); endproperty
	a_wake: assert property (p_wake) else $error("wake awake");
	property p_wake1; wake |=> !wake; endproperty
	a_wake1: assert property (p_wake1) else $error("wake long");
endmodule // gated_timer_chk
bind gated_timer gated_timer_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sleep_mode(sleep_mode), .wake(wake), .overflow_pulse(overflow_pulse));
`default_nettype wire

/* verification/gated_timer_tb.sv */
// self-checking bench for the gated timer
`timescale 1ns/100ps
`default_nettype none
module gated_timer_tb;
	localparam int HALF = 2;
	localparam int LF_HALF = 8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic run, gate_req, ext_pin, lf_osc, gpin, oth, cmp, slp;
	logic irq, wake, ovf;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata, r;
	int errors, total_checks, n;
	gated_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_count_pin(ext_pin), .low_freq_internal_osc(lf_osc),
		.gate_pin(gpin), .other_timer_overflow(oth),
		.comparator_out_synced(cmp), .sleep_mode(slp), .irq(irq),
		.wake(wake), .overflow_pulse(ovf));
	pin_model #(.HALF(HALF), .LF_HALF(LF_HALF)) pm (.pclk(pclk),
		.presetn(presetn), .run(run), .gate_req(gate_req),
		.external_count_pin(ext_pin), .low_freq_internal_osc(lf_osc),
		.gate_pin(gpin));
	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge pclk);
		if (k == 20)
			errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task set_count(input logic [15:0] v);
		apb(1'b1, timer_pkg::OFS_COUNT_LOW, {24'h0, v[7:0]});
		apb(1'b1, timer_pkg::OFS_COUNT_HIGH, {24'h0, v[15:8]});
	endtask
	task get_count(output logic [15:0] v);
		apb(1'b0, timer_pkg::OFS_COUNT_LOW, 32'h0);
		v[7:0] = r[7:0];
		apb(1'b0, timer_pkg::OFS_COUNT_HIGH, 32'h0);
		v[15:8] = r[7:0];
	endtask
	task meas(input logic [5:0] ctl, input int cyc, output int d);
		logic [15:0] v;
		set_count(16'h0000);
		apb(1'b1, timer_pkg::OFS_CONTROL, {26'h0, ctl});
		repeat (cyc) @(posedge pclk);
		apb(1'b1, timer_pkg::OFS_CONTROL, 32'h0);
		get_count(v);
		d = v;
	endtask
	task set_src(input int s, input logic v);
		gate_req <= (s == 0 || s == 3) ? v : !v;
		oth <= s == 1 ? v : !v;
		cmp <= s == 2 ? v : !v;
		repeat (4) @(posedge pclk);
	endtask
	function automatic logic near(int d, int cyc, int div);
		return d >= (cyc + 4) / div - 3 && d <= (cyc + 4) / div + 3;
	endfunction
	function automatic int div_of(int s);
		return s == 0 ? 4 : s == 1 ? 1 : s == 2 ? 2 * HALF : 2 * LF_HALF;
	endfunction
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial
	begin
		#400_000;
		errors++;
		tally_and_finish;
	end
	initial
	begin : main
		logic [15:0] v, w;
		logic [7:0] b;
		logic en;
		int d, s, p;
		errors = 0;
		total_checks = 0;
		{presetn, psel, penable, pwrite, run, gate_req, oth, cmp, slp} = 9'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		void'($urandom(75));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 24; a += 4)
		begin
			apb(1'b0, 8'(a), 32'h0);
			chk(r & 32'hFFFFFFDF, 32'h0);
			chk({31'h0, e}, {31'h0, a == 24});
		end
		v = 16'($urandom);
		set_count(v);
		pstrb <= 4'hE;
		apb(1'b1, timer_pkg::OFS_COUNT_LOW, {24'h0, ~v[7:0]});
		pstrb <= 4'hF;
		get_count(w);
		chk({16'h0, w}, {16'h0, v});
		b = 8'($urandom) & 8'h3E;
		apb(1'b1, timer_pkg::OFS_CONTROL, {24'h0, b});
		apb(1'b0, timer_pkg::OFS_CONTROL, 32'h0);
		chk(r, {24'h0, b});
		for (p = 0; p < 4; p++)
		begin
			meas({2'h1, 2'(p), 1'($urandom), 1'b1}, 512, d);
			chk({31'h0, near(d, 512, 1 << p)}, 32'h1);
		end
		run <= 1'b1;
		for (s = 0; s < 4; s++)
		begin
			p = $urandom % 4;
			meas({2'(s), 2'(p), 1'($urandom), 1'b1}, 1024, d);
			chk({31'h0, near(d, 1024, div_of(s) << p)}, 32'h1);
		end
		run <= 1'b0;
		for (s = 0; s < 4; s++)
		begin
			p = $urandom % 2;
			for (int act = 0; act < 2; act++)
			begin
				set_src(s, act[0] ? p[0] : !p[0]);
				apb(1'b1, timer_pkg::OFS_GATE, {24'h0, 2'(s), 4'h0, 1'(p), 1'b1});
				meas(6'h11, 256, d);
				// reserved source reads as a constant low
				en = s == 3 ? !p[0] : act[0];
				chk({31'h0, en ? near(d, 256, 1) : d == 0}, 32'h1);
			end
		end
		set_src(0, 1'b0);
		apb(1'b1, timer_pkg::OFS_GATE, 32'h1B);
		apb(1'b0, timer_pkg::OFS_GATE, 32'h0);
		chk({31'h0, r[4]}, 32'h1);
		apb(1'b1, timer_pkg::OFS_INT_STATUS, 32'h3);
		apb(1'b0, timer_pkg::OFS_INT_STATUS, 32'h0);
		chk({31'h0, r[1]}, 32'h0);
		set_src(0, 1'b1);
		set_src(0, 1'b0);
		apb(1'b0, timer_pkg::OFS_GATE, 32'h0);
		chk({31'h0, r[4]}, 32'h0);
		apb(1'b0, timer_pkg::OFS_INT_STATUS, 32'h0);
		chk({31'h0, r[1]}, 32'h1);
		apb(1'b1, timer_pkg::OFS_GATE, 32'h07);
		apb(1'b0, timer_pkg::OFS_GATE, 32'h0);
		b = r[7:0];
		for (int i = 0; i < 2; i++)
		begin
			set_src(0, 1'b1);
			set_src(0, 1'b0);
			apb(1'b0, timer_pkg::OFS_GATE, 32'h0);
			chk({31'h0, r[5]}, {31'h0, b[5] ^ (i == 0)});
		end
		apb(1'b1, timer_pkg::OFS_GATE, 32'h0);
		apb(1'b1, timer_pkg::OFS_INT_STATUS, 32'h3);
		apb(1'b1, timer_pkg::OFS_INT_MASK, 32'h1);
		set_count(16'hFFF0);
		apb(1'b1, timer_pkg::OFS_CONTROL, 32'h11);
		for (n = 0; n < 100 && ovf !== 1'b1; n++)
			@(posedge pclk);
		chk({31'h0, ovf}, 32'h1);
		apb(1'b1, timer_pkg::OFS_CONTROL, 32'h0);
		apb(1'b0, timer_pkg::OFS_INT_STATUS, 32'h0);
		chk({r[31:1], irq}, 32'h1);
		apb(1'b1, timer_pkg::OFS_INT_MASK, 32'h0);
		apb(1'b1, timer_pkg::OFS_INT_STATUS, 32'h1);
		apb(1'b0, timer_pkg::OFS_INT_STATUS, 32'h0);
		chk({r[31:1], irq}, 32'h0);
		set_count(16'hFFF0);
		slp <= 1'b1;
		run <= 1'b1;
		apb(1'b1, timer_pkg::OFS_CONTROL, 32'h23);
		for (n = 0; n < 200 && wake !== 1'b1; n++)
			@(posedge pclk);
		chk({31'h0, wake}, 32'h1);
		apb(1'b1, timer_pkg::OFS_CONTROL, 32'h0);
		meas(6'h21, 200, d);
		chk(d, 32'h0);
		slp <= 1'b0;
		run <= 1'b0;
		tally_and_finish;
	end
endmodule // gated_timer_tb
`default_nettype wire

/* verification/pin_model.sv */
// far-side model: external count pin, slow oscillator, gate pin
`timescale 1ns/100ps
`default_nettype none
module pin_model #(
	parameter int HALF = 2,
	parameter int LF_HALF = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic gate_req,
	output logic external_count_pin,
	output logic low_freq_internal_osc,
	output logic gate_pin
);
	int cnt;
	int lf;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 0;
			lf <= 0;
			external_count_pin <= 1'b0;
			low_freq_internal_osc <= 1'b0;
			gate_pin <= 1'b0;
		end
		else
		begin
			gate_pin <= gate_req;
			lf <= (lf == LF_HALF - 1) ? 0 : lf + 1;
			if (lf == LF_HALF - 1)
				low_freq_internal_osc <= !low_freq_internal_osc;
			cnt <= (run && cnt != HALF - 1) ? cnt + 1 : 0;
			if (run && cnt == HALF - 1)
				external_count_pin <= !external_count_pin;
			else if (!run)
				external_count_pin <= 1'b0;
		end
	end
endmodule // pin_model
`default_nettype wire
